// ---- pkg/ldmc_pkg.sv ----
package ldmc_pkg;
    // Printed register offsets are indices; the APB byte address is four times the index.
    localparam logic [19:0] DMC_IDX      = 20'h1FFE2;  // Display mode control index.
    localparam logic [19:0] PMC_IDX      = 20'h1FFE3;  // Power mode control index.
    localparam logic [19:0] CFG_IDX      = 20'h1FFF0;  // Panel configuration index.
    localparam logic [19:0] STAT_IDX     = 20'h1FFF1;  // Mode status index.
    localparam logic [19:0] FCNT_IDX     = 20'h1FFF2;  // Frame counter index.
    localparam int          ADDR_W       = 20;         // APB address width.
    localparam int          DATA_W       = 32;         // APB data width.
    localparam int          PIX_W        = 12;         // Panel data width.
    localparam int          FCNT_W       = 18;         // Frame counter width.
    localparam logic [17:0] FCNT_MAX     = 18'h3FFFF;  // Frame counter wrap value.
    // Display mode control fields.
    localparam int          DMC_BPP_HI   = 7;
    localparam int          DMC_BPP_LO   = 6;
    localparam int          DMC_HIPERF   = 5;
    localparam int          DMC_CLKDIV   = 4;
    localparam int          DMC_BLANK    = 3;
    localparam int          DMC_FREPEAT  = 2;
    localparam int          DMC_HWINV    = 1;
    localparam int          DMC_SWINV    = 0;
    // Panel configuration fields.
    localparam int          CFG_PTYPE    = 7;
    localparam int          CFG_COLOR    = 5;
    localparam int          CFG_GENERAL_IO_FOUR    = 3;
    localparam int          CFG_RDIV_HI  = 2;
    localparam int          CFG_RDIV_LO  = 1;
    localparam int          CFG_ROT      = 0;
    // Reset values and implemented bit masks.
    localparam logic [7:0]  DMC_RST      = 8'h00;
    localparam logic [7:0]  PMC_RST      = 8'h00;
    localparam logic [7:0]  PMC_MASK     = 8'h0F;
    localparam logic [7:0]  CFG_RST      = 8'h00;
    localparam logic [7:0]  CFG_MASK     = 8'hAF;
    // Depth code for eight bits per pixel and the reserved depth value.
    localparam logic [1:0]  BPP_8        = 2'h3;
    localparam logic [3:0]  DEPTH_RSVD   = 4'h0;
endpackage : ldmc_pkg

// ---- logic/ldmc_sync.sv ----
`timescale 1ns/1ps
// Two-stage synchroniser for a level arriving from a pin.
module ldmc_sync (
    input  wire logic clk_i,
    input  wire logic srst_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic meta_reg;  // First stage, read only by the second stage.

    // Both stages clear on reset and then shift the pin level in.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            meta_reg <= 1'b0;
            q_o      <= 1'b0;
        end else begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end
endmodule // ldmc_sync

// ---- logic/ldmc_clk_div.sv ----
`timescale 1ns/1ps
// Produces the pixel and memory clock enables as one-cycle pulses.
module ldmc_clk_div (
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    input  wire logic       half_i,
    input  wire logic [1:0] mdiv_log2_i,
    output logic            pclk_en_o,
    output logic            mclk_en_o
);
    logic       phase_reg;  // Alternates for the halved operating clock.
    logic [2:0] mcnt_reg;   // Counts pixel clock pulses.
    logic       op_en;      // Operating clock enable.
    logic [2:0] mmask;      // Low count bits that must be zero.

    // The operating clock runs every cycle or every second cycle.
    assign op_en = half_i ? phase_reg : 1'b1;
    assign mmask = 3'((4'h1 << mdiv_log2_i) - 4'h1);

    // Phase toggle and pixel count advance.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            phase_reg <= 1'b0;
            mcnt_reg  <= 3'h0;
        end else begin
            phase_reg <= ~phase_reg;
            if (op_en) begin
                mcnt_reg <= mcnt_reg + 3'h1;
            end
        end
    end

    // The pixel clock equals the operating clock; the memory clock fires on
    // every 2^n-th pixel pulse.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pclk_en_o <= 1'b0;
            mclk_en_o <= 1'b0;
        end else begin
            pclk_en_o <= op_en;
            mclk_en_o <= op_en && ((mcnt_reg & mmask) == 3'h0);
        end
    end
endmodule // ldmc_clk_div

// ---- logic/ldmc_top.sv ----
`timescale 1ns/1ps
module ldmc_top
    import ldmc_pkg::*;
(
    input  wire logic                         clk_i,
    input  wire logic                         srst_i,
    input  wire logic                         psel_i,
    input  wire logic                         penable_i,
    input  wire logic                         pwrite_i,
    input  wire logic [ldmc_pkg::ADDR_W-1:0]  paddr_i,
    input  wire logic [ldmc_pkg::DATA_W-1:0]  pwdata_i,
    output logic      [ldmc_pkg::DATA_W-1:0]  prdata_o,
    output logic                              pready_o,
    output logic                              pslverr_o,
    input  wire logic [ldmc_pkg::PIX_W-1:0]   lut_data_i,
    input  wire logic                         frame_tick_i,
    output logic      [ldmc_pkg::PIX_W-2:0]   panel_data_lines_o,
    input  wire logic                         panel_data_eleven_i,
    output logic                              panel_data_eleven_o,
    output logic                              panel_data_eleven_oe_o,
    output logic                              pclk_en_o,
    output logic                              mclk_en_o,
    output logic      [3:0]                   pixel_depth_o,
    output logic      [ldmc_pkg::FCNT_W-1:0]  frame_count_o
);
    import ldmc_pkg::*;

    // Software-visible registers.
    logic [7:0]        dmc_reg;     // Display mode control.
    logic [7:0]        pmc_reg;     // Power mode control, stored only.
    logic [7:0]        cfg_reg;     // Panel configuration.
    logic [3:0]        depth_reg;   // Decoded bits per pixel.
    logic              rsvd_reg;    // Reserved depth selected.
    logic [FCNT_W-1:0] fcnt_reg;    // Frame counter.
    logic              inv_reg;     // Registered inversion decision.

    // Decoded controls.
    logic              passive;     // Passive panel selected.
    logic              color;       // Colour panel selected.
    logic              rot;         // Rotated view active.
    logic              hwinv;       // Hardware invert enable.
    logic              pin_sync;    // Synchronised pin eleven level.
    logic              inv_sel;     // Inversion decision.
    logic [1:0]        mdiv_log2;   // Memory divider exponent.
    logic [3:0]        depth_next;  // Next decoded depth.
    logic              rsvd_next;   // Next reserved flag.
    logic [PIX_W-1:0]  pix_next;    // Next panel data word.

    // APB decode.
    logic              setup;       // Setup phase of a transfer.
    logic              wr_en;       // Write completes this edge.
    logic [ADDR_W-1:0] idx;         // Word index from the byte address.
    logic [DATA_W-1:0] rd_next;     // Read data for the current index.
    logic              hit;         // Index is mapped.

    assign passive   = ~cfg_reg[CFG_PTYPE];
    assign color     = cfg_reg[CFG_COLOR];
    assign rot       = cfg_reg[CFG_ROT];
    assign hwinv     = dmc_reg[DMC_HWINV];
    assign setup     = psel_i & ~penable_i;
    assign wr_en     = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;
    assign idx       = {2'h0, paddr_i[ADDR_W-1:2]};

    // Depth decode; code 3 is only legal on colour panels.
    always_comb begin
        rsvd_next  = 1'b0;
        unique case (dmc_reg[DMC_BPP_HI:DMC_BPP_LO])
            2'h0: depth_next = 4'h1;
            2'h1: depth_next = 4'h2;
            2'h2: depth_next = 4'h4;
            2'h3: begin
                depth_next = color ? 4'h8 : DEPTH_RSVD;
                rsvd_next  = ~color;
            end
        endcase
    end

    // Memory divider choice; rotated view takes its own field instead.
    always_comb begin
        if (rot) begin
            mdiv_log2 = cfg_reg[CFG_RDIV_HI:CFG_RDIV_LO];
        end else if (dmc_reg[DMC_HIPERF]) begin
            mdiv_log2 = 2'h0;
        end else begin
            mdiv_log2 = 2'(~dmc_reg[DMC_BPP_HI:DMC_BPP_LO]);
        end
    end

    // Inversion source: pin on passive panels with hardware enable, else bit.
    assign inv_sel = (hwinv && passive) ? pin_sync : dmc_reg[DMC_SWINV];

    // Panel word: post-lookup data, optionally inverted, or zero when blanked.
    always_comb begin
        if (dmc_reg[DMC_BLANK]) begin
            pix_next = '0;
        end else if (inv_sel) begin
            pix_next = ~lut_data_i;
        end else begin
            pix_next = lut_data_i;
        end
    end

    // Read multiplexer.
    always_comb begin
        rd_next = '0;
        hit     = 1'b1;
        if (idx == DMC_IDX) begin
            rd_next[7:0] = dmc_reg;
        end else if (idx == PMC_IDX) begin
            rd_next[7:0] = pmc_reg;
        end else if (idx == CFG_IDX) begin
            rd_next[7:0] = cfg_reg;
        end else if (idx == STAT_IDX) begin
            rd_next[6:0] = {inv_reg, pin_sync, rsvd_reg, depth_reg};
        end else if (idx == FCNT_IDX) begin
            rd_next[FCNT_W-1:0] = fcnt_reg;
        end else begin
            hit = 1'b0;
        end
    end

    // Pin eleven synchroniser.
    ldmc_sync u_sync (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .d_i    (panel_data_eleven_i),
        .q_o    (pin_sync)
    );

    // Clock enables; pixel clock is always the operating clock here.
    ldmc_clk_div u_div (
        .clk_i       (clk_i),
        .srst_i      (srst_i),
        .half_i      (dmc_reg[DMC_CLKDIV]),
        .mdiv_log2_i (mdiv_log2),
        .pclk_en_o   (pclk_en_o),
        .mclk_en_o   (mclk_en_o)
    );

    // APB answer: ready in the access phase, one wait-free cycle.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= '0;
        end else if (setup) begin
            pready_o  <= 1'b1;
            pslverr_o <= ~hit;
            prdata_o  <= pwrite_i ? '0 : rd_next;
        end else begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end
    end

    // Register writes; unimplemented bits stay zero.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            dmc_reg <= DMC_RST;
            pmc_reg <= PMC_RST;
            cfg_reg <= CFG_RST;
        end else if (wr_en) begin
            if (idx == DMC_IDX) begin
                dmc_reg <= pwdata_i[7:0];
            end
            if (idx == PMC_IDX) begin
                pmc_reg <= pwdata_i[7:0] & PMC_MASK;
            end
            if (idx == CFG_IDX) begin
                cfg_reg <= pwdata_i[7:0] & CFG_MASK;
            end
        end
    end

    // Decoded status registers.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            depth_reg     <= 4'h1;
            rsvd_reg      <= 1'b0;
            inv_reg       <= 1'b0;
            pixel_depth_o <= 4'h1;
        end else begin
            depth_reg     <= depth_next;
            rsvd_reg      <= rsvd_next;
            inv_reg       <= inv_sel;
            pixel_depth_o <= depth_next;
        end
    end

    // Frame counter runs only while repeat is enabled, else held at zero.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            fcnt_reg <= '0;
        end else if (!dmc_reg[DMC_FREPEAT]) begin
            fcnt_reg <= '0;
        end else if (frame_tick_i) begin
            fcnt_reg <= (fcnt_reg == FCNT_MAX) ? '0 : fcnt_reg + 18'h1;
        end
    end

    // Frame count output copy.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            frame_count_o <= '0;
        end else begin
            frame_count_o <= fcnt_reg;
        end
    end

    // Panel data and the shared pin eleven.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            panel_data_lines_o     <= '0;
            panel_data_eleven_o    <= 1'b0;
            panel_data_eleven_oe_o <= 1'b0;
        end else begin
            panel_data_lines_o <= pix_next[PIX_W-2:0];
            if (!passive) begin
                // Active panels use pin eleven as a data line.
                panel_data_eleven_o    <= pix_next[PIX_W-1];
                panel_data_eleven_oe_o <= 1'b1;
            end else if (hwinv) begin
                // Invert input: the device stops driving.
                panel_data_eleven_o    <= 1'b0;
                panel_data_eleven_oe_o <= 1'b0;
            end else begin
                // General purpose output four.
                panel_data_eleven_o    <= cfg_reg[CFG_GENERAL_IO_FOUR];
                panel_data_eleven_oe_o <= 1'b1;
            end
        end
    end

    // Checks.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    logic [3:0] pcount;  // Pixel pulses since the last memory pulse.
    logic [3:0] plimit;  // Largest legal pixel count for the divider.

    assign plimit = 4'((5'h1 << mdiv_log2) - 5'h1);

    // Helper counter restarted by each memory pulse or a divider change.
    always_ff @(posedge clk_i) begin
        if (srst_i || mclk_en_o || (mdiv_log2 != $past(mdiv_log2))) begin
            pcount <= 4'h0;
        end else if (pclk_en_o) begin
            pcount <= pcount + 4'h1;
        end
    end

    a_depth_eight: assert property (
        (pixel_depth_o == 4'h8) |-> $past(dmc_reg[DMC_BPP_HI:DMC_BPP_LO] == BPP_8 && color))
        else $error("Eight bits per pixel without colour and code 3.");

    a_mclk_ratio: assert property (
        $stable(mdiv_log2) && $past($stable(mdiv_log2)) |-> pcount <= plimit)
        else $error("Memory clock slower than the depth ratio.");

    a_mclk_hiperf: assert property (
        (dmc_reg[DMC_HIPERF] && !rot) [*3] ##1 pclk_en_o |-> mclk_en_o)
        else $error("High performance memory clock missed a pixel pulse.");

    a_rot_divider: assert property (
        rot |-> mdiv_log2 == cfg_reg[CFG_RDIV_HI:CFG_RDIV_LO])
        else $error("Rotated view did not use its own divider.");

    a_op_half: assert property (
        dmc_reg[DMC_CLKDIV] [*2] ##0 pclk_en_o |=> !pclk_en_o)
        else $error("Halved operating clock fired twice in a row.");

    a_op_full: assert property (
        !dmc_reg[DMC_CLKDIV] [*3] |-> pclk_en_o)
        else $error("Undivided pixel clock missed a cycle.");

    a_blank_low: assert property (
        $past(dmc_reg[DMC_BLANK]) |-> panel_data_lines_o == '0)
        else $error("Panel data not low while blanked.");

    a_frame_wrap: assert property (
        dmc_reg[DMC_FREPEAT] && frame_tick_i && fcnt_reg == FCNT_MAX |=> fcnt_reg == '0)
        else $error("Frame counter did not wrap.");

    a_pin_input: assert property (
        $past(passive && hwinv) |-> !panel_data_eleven_oe_o)
        else $error("Pin eleven driven while used as invert input.");

    a_video_inv: assert property (
        $past(!dmc_reg[DMC_BLANK] && inv_sel) |-> panel_data_lines_o == ~$past(lut_data_i[PIX_W-2:0]))
        else $error("Inverted data does not match the lookup output.");

    // Polarity checks: the software bit rules unless the passive pin is enabled.
    // The reset cycle is excluded, since the panel data registers are cleared there.
    a_sw_invert: assert property (
        $past(!srst_i && !dmc_reg[DMC_BLANK] && !hwinv) |->
            panel_data_lines_o == ($past(dmc_reg[DMC_SWINV]) ? ~$past(lut_data_i[PIX_W-2:0])
                                                              : $past(lut_data_i[PIX_W-2:0])))
        else $error("Software invert bit did not set the video polarity.");

    a_hw_invert: assert property (
        $past(!srst_i && !dmc_reg[DMC_BLANK] && hwinv && passive) |->
            panel_data_lines_o == ($past(pin_sync) ? ~$past(lut_data_i[PIX_W-2:0])
                                                   : $past(lut_data_i[PIX_W-2:0])))
        else $error("Invert pin level did not set the video polarity.");

    // Pin eleven sharing: general output on passive panels with hardware invert off, top data bit on active ones.
    a_gpio_out: assert property (
        $past(!srst_i && passive && !hwinv) |->
            panel_data_eleven_oe_o && panel_data_eleven_o == $past(cfg_reg[CFG_GENERAL_IO_FOUR]))
        else $error("Pin eleven did not drive the general purpose level.");

    a_active_pin: assert property (
        $past(!srst_i && !passive && !dmc_reg[DMC_BLANK]) |->
            panel_data_eleven_oe_o && panel_data_eleven_o == $past(dmc_reg[DMC_SWINV] ^ lut_data_i[PIX_W-1]))
        else $error("Active panel pin eleven is not the top data bit.");

    // Depth decoding for the narrow codes and the reserved monochrome code.
    a_depth_code: assert property (
        $past(!srst_i && dmc_reg[DMC_BPP_HI:DMC_BPP_LO] != BPP_8) |->
            pixel_depth_o == 4'(4'h1 << $past(dmc_reg[DMC_BPP_HI:DMC_BPP_LO])))
        else $error("Depth code did not give 1, 2 or 4 bits per pixel.");

    a_mono_rsvd: assert property (
        $past(!srst_i && !color && dmc_reg[DMC_BPP_HI:DMC_BPP_LO] == BPP_8) |-> pixel_depth_o == DEPTH_RSVD)
        else $error("Reserved depth on a monochrome panel was not flagged.");

    // The halved clock must alternate, so a quiet cycle is followed by a pulse.
    a_op_half_on: assert property (
        dmc_reg[DMC_CLKDIV] [*2] ##0 !pclk_en_o |=> pclk_en_o)
        else $error("Halved operating clock skipped a pulse.");

    // With repeat off the counter must sit at zero, whatever the frame ticks do.
    a_frame_hold: assert property (
        !dmc_reg[DMC_FREPEAT] |=> fcnt_reg == '0)
        else $error("Frame counter moved while repeat was off.");
endmodule // ldmc_top

// ---- dv/ldmc_panel.sv ----
`timescale 1ns/1ps
// Panel-side model of the shared pin eleven.
// The panel drives its invert switch level whenever the controller releases the pin.
module ldmc_panel (
    input  wire logic pin_o_i,    // Controller's drive level on pin eleven.
    input  wire logic pin_oe_i,   // Controller's drive enable on pin eleven.
    input  wire logic inv_lvl_i,  // Invert switch level chosen by the bench.
    output logic      pin_lvl_o   // Resolved level seen on the wire.
);
    // The wire follows whichever party drives it, so no level is ever left floating.
    assign pin_lvl_o = pin_oe_i ? pin_o_i : inv_lvl_i;
endmodule // ldmc_panel

// ---- dv/ldmc_tb.sv ----
`timescale 1ns/1ps
// Self-checking bench for the display mode control block.
module testbench;
    import ldmc_pkg::*;
    logic        clk_i = 1'b0;         // 25 MHz clock.
    logic        srst_i = 1'b1;        // Synchronous reset, held at start.
    logic        psel_i = 1'b0;        // APB select.
    logic        penable_i = 1'b0;     // APB enable.
    logic        pwrite_i = 1'b0;      // APB direction.
    logic [19:0] paddr_i = '0;         // APB byte address.
    logic [31:0] pwdata_i = '0;        // APB write data.
    logic [31:0] prdata_o;             // APB read data.
    logic        pready_o;             // APB ready.
    logic        pslverr_o;            // APB error.
    logic [11:0] lut_data_i = '0;      // Pixel word after the lookup table.
    logic        frame_tick_i = 1'b0;  // Frame pulse.
    logic [10:0] panel_data_lines_o;   // Panel data.
    logic        pin_lvl;              // Resolved pin eleven level.
    logic        pin_o;                // Controller drive on pin eleven.
    logic        pin_oe;               // Controller enable on pin eleven.
    logic        inv_lvl = 1'b0;       // Panel invert switch.
    logic        pclk_en_o;            // Pixel clock enable.
    logic        mclk_en_o;            // Memory clock enable.
    logic [3:0]  pixel_depth_o;        // Bits per pixel.
    logic [17:0] frame_count_o;        // Frame counter.
    int          n_errors = 0;         // Mismatches seen.
    int          samples_checked = 0;  // Comparisons made.
    int          dmc;                  // Model copy of the display mode register.
    int          cfg;                  // Model copy of the panel configuration register.

    // The clock toggles every half period of 20 ns.
    initial begin
        forever #20 clk_i = ~clk_i;
    end

    ldmc_top i_dut (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .lut_data_i(lut_data_i), .frame_tick_i(frame_tick_i),
        .panel_data_lines_o(panel_data_lines_o), .panel_data_eleven_i(pin_lvl),
        .panel_data_eleven_o(pin_o), .panel_data_eleven_oe_o(pin_oe), .pclk_en_o(pclk_en_o),
        .mclk_en_o(mclk_en_o), .pixel_depth_o(pixel_depth_o), .frame_count_o(frame_count_o));

    ldmc_panel i_panel (.pin_o_i(pin_o), .pin_oe_i(pin_oe), .inv_lvl_i(inv_lvl), .pin_lvl_o(pin_lvl));

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Compares a seen value with the model's value and counts the outcome.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // One APB transfer; the request is held until pready is sampled high.
    task automatic apb(input bit wr, input logic [19:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int k;
        @(posedge clk_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= wr;
        paddr_i   <= {idx[17:0], 2'b00};
        pwdata_i  <= wd;
        @(posedge clk_i);
        penable_i <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge clk_i);
            if (pready_o === 1'b1) break;
        end
        if (k == 20) begin
            n_errors++;
            stop_test();
        end
        rd = prdata_o;
        err = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask

    // Measures the spacing in cycles between two enable pulses of one kind.
    task automatic gap(input bit m, output int g);
        int k;
        for (k = 0; k < 64; k++) begin
            @(posedge clk_i);
            #1;
            if ((m ? mclk_en_o : pclk_en_o) === 1'b1) break;
        end
        for (g = 1; g < 64; g++) begin
            @(posedge clk_i);
            #1;
            if ((m ? mclk_en_o : pclk_en_o) === 1'b1) break;
        end
        if (k == 64 || g == 64) begin
            n_errors++;
            stop_test();
        end
    endtask

    // Model of the pixel path: blanking wins, then hardware or software inversion.
    function automatic logic [11:0] pix_exp(input int d);
        int inv;
        inv = (cfg[7] == 0 && dmc[1]) ? int'(inv_lvl) : dmc[0];
        if (dmc[3]) return 12'h000;
        return 12'(inv ? ~d : d);
    endfunction

    // Main sequence.
    initial begin
        logic [31:0] rd;
        logic        err;
        int          d;
        int          g;
        logic [11:0] px;
        logic [19:0] idxs [3];
        idxs = '{DMC_IDX, PMC_IDX, CFG_IDX};
        void'($urandom(19));
        repeat (10) @(posedge clk_i);
        srst_i <= 1'b0;
        // Reset values, masking of the second mode register and an unmapped place.
        foreach (idxs[n]) begin
            apb(0, idxs[n], 32'h0, rd, err);
            check(rd, 32'h0, "register reset value");
        end
        apb(1, PMC_IDX, 32'hFFFFFFFF, rd, err);
        apb(0, PMC_IDX, 32'h0, rd, err);
        check(rd, 32'h0000000F, "second mode register");
        apb(0, 20'h00010, 32'h0, rd, err);
        check(err, 1'b1, "unmapped error");
        $display("register test done");
        // Every depth code with colour, high performance and input halving.
        for (int i = 0; i < 32; i++) begin
            cfg = i[4] << 5;
            dmc = (i[1:0] << 6) | (i[2] << 5) | (i[3] << 4);
            apb(1, CFG_IDX, cfg, rd, err);
            apb(1, DMC_IDX, dmc, rd, err);
            repeat (4) @(posedge clk_i);
            #1;
            check(pixel_depth_o, (i[1:0] == 3 && !i[4]) ? 0 : 1 << i[1:0], "depth");
            gap(0, g);
            check(g, i[3] ? 2 : 1, "pixel clock gap");
            gap(1, g);
            check(g, (i[3] ? 2 : 1) << ((i[2] || i[1:0] == 3) ? 0 : 3 - i[1:0]), "memory gap");
        end
        // Rotated view with high performance set: the rotated divider decides.
        cfg = 32'h05;
        apb(1, CFG_IDX, cfg, rd, err);
        apb(1, DMC_IDX, 32'h20, rd, err);
        gap(1, g);
        gap(1, g);
        check(g, 4, "rotated memory gap");
        // Host raises high performance for a large update, then drops it to save power.
        cfg = 32'h00;
        apb(1, CFG_IDX, cfg, rd, err);
        apb(1, DMC_IDX, 32'h20, rd, err);
        gap(1, g);
        gap(1, g);
        check(g, 1, "update memory gap");
        apb(1, DMC_IDX, 32'h00, rd, err);
        gap(1, g);
        gap(1, g);
        check(g, 8, "idle memory gap");
        $display("clock test done");
        // Pixel path over panel type, blanking, both inversion sources and the pin level.
        for (int i = 0; i < 32; i++) begin
            cfg = (i[0] << 7) | 32'h08;
            dmc = (i[1] << 3) | (i[2] << 1) | i[3];
            @(posedge clk_i);
            inv_lvl <= i[4];
            apb(1, CFG_IDX, cfg, rd, err);
            apb(1, DMC_IDX, dmc, rd, err);
            repeat (4) @(posedge clk_i);
            #1;
            check(pin_oe, i[0] || !i[2], "pin eleven enable");
            if (!i[0] && !i[2]) check(pin_o, 1'b1, "general io level");
            for (int j = 0; j < 8; j++) begin
                d = $urandom_range(0, 4095);
                @(posedge clk_i);
                lut_data_i <= 12'(d);
                @(posedge clk_i);
                #1;
                px = pix_exp(d);
                check(panel_data_lines_o, px[10:0], "pixel");
                if (i[0]) check(pin_o, px[11], "active pin eleven");
            end
        end
        $display("pixel test done");
        // Frame counting with repeat on, then cleared with repeat off; the wrap is too long to run.
        apb(1, DMC_IDX, 32'h04, rd, err);
        repeat (5) begin
            @(posedge clk_i);
            frame_tick_i <= 1'b1;
            @(posedge clk_i);
            frame_tick_i <= 1'b0;
        end
        apb(0, FCNT_IDX, 32'h0, rd, err);
        check(rd, 32'h5, "frame count read");
        check(frame_count_o, 18'h5, "frame count port");
        apb(1, DMC_IDX, 32'h00, rd, err);
        repeat (3) begin
            @(posedge clk_i);
            frame_tick_i <= 1'b1;
            @(posedge clk_i);
            frame_tick_i <= 1'b0;
        end
        repeat (2) @(posedge clk_i);
        #1;
        check(frame_count_o, 18'h0, "frame count held");
        $display("frame test done");
        stop_test();
    end
endmodule // testbench
